// *** rtl/audio_fifo_dma_event.sv ***
`include "audio_fifo_params.svh"
module audio_fifo_dma_event
   import audio_fifo_pkg::*;
#(
   parameter int DEPTH = `MAIN_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Control
   input wire logic [31:0] rx_fifo_control,
   input wire logic [31:0] tx_fifo_control,
   input wire audio_fifo_pkg::dma_sel_t dma_select,
   input wire logic err_clear,
   // Receive pin side
   input wire logic rx_pin_valid,
   output logic rx_pin_ready,
   input wire audio_fifo_pkg::word_t rx_pin_data,
   // Receive DMA side
   output logic rx_dma_valid,
   input wire logic rx_dma_ready,
   output audio_fifo_pkg::word_t rx_dma_data,
   // Transmit DMA side
   input wire logic tx_dma_valid,
   output logic tx_dma_ready,
   input wire audio_fifo_pkg::word_t tx_dma_data,
   // Transmit pin side
   output logic tx_pin_valid,
   input wire logic tx_pin_ready,
   output audio_fifo_pkg::word_t tx_pin_data,
   // Events and errors
   output logic rx_req_enhanced_dma_controller,
   output logic rx_req_sdma,
   output logic tx_req_enhanced_dma_controller,
   output logic tx_req_sdma,
   output logic rx_overflow,
   output logic tx_underflow
);
   import audio_fifo_pkg::*;
   localparam int LW = $clog2(DEPTH) + 1;

   // ----------------------------------------
   // Data storage
   // ----------------------------------------
   word_t rx_st_data, rx_sk_data, tx_st_data;
   logic rx_st_valid, rx_st_ready, rx_sk_valid, rx_sk_ready;
   logic tx_st_valid, tx_st_ready, tx_sk_valid, tx_sk_ready;
   logic [LW-1:0] rx_lvl, tx_lvl;

   // Receive: pins feed the main store through a small skid buffer
   stream_fifo #(.WIDTH(`WORD_WIDTH), .DEPTH(`SIDE_FIFO_DEPTH)) u_rx_skid (
      .clk(clk), .nrst(nrst), .ce(ce), .clr(1'b0),
      .in_valid(rx_pin_valid), .in_ready(rx_sk_ready), .in_data(rx_pin_data),
      .out_valid(rx_sk_valid), .out_ready(rx_st_ready), .out_data(rx_sk_data),
      .level());
   stream_fifo #(.WIDTH(`WORD_WIDTH), .DEPTH(DEPTH)) u_rx_main (
      .clk(clk), .nrst(nrst), .ce(ce), .clr(1'b0),
      .in_valid(rx_sk_valid), .in_ready(rx_st_ready), .in_data(rx_sk_data),
      .out_valid(rx_st_valid), .out_ready(rx_dma_ready), .out_data(rx_st_data),
      .level(rx_lvl));
   // Transmit: DMA feeds main store, small buffer toward pins
   stream_fifo #(.WIDTH(`WORD_WIDTH), .DEPTH(DEPTH)) u_tx_main (
      .clk(clk), .nrst(nrst), .ce(ce), .clr(1'b0),
      .in_valid(tx_dma_valid), .in_ready(tx_st_ready), .in_data(tx_dma_data),
      .out_valid(tx_st_valid), .out_ready(tx_sk_ready), .out_data(tx_st_data),
      .level(tx_lvl));
   stream_fifo #(.WIDTH(`WORD_WIDTH), .DEPTH(`SIDE_FIFO_DEPTH)) u_tx_skid (
      .clk(clk), .nrst(nrst), .ce(ce), .clr(1'b0),
      .in_valid(tx_st_valid), .in_ready(tx_sk_ready), .in_data(tx_st_data),
      .out_valid(tx_sk_valid), .out_ready(tx_pin_ready), .out_data(tx_pin_data),
      .level());

   assign rx_pin_ready = rx_sk_ready;
   assign rx_dma_valid = rx_st_valid;
   assign rx_dma_data = rx_st_data;
   assign tx_dma_ready = tx_st_ready;
   assign tx_pin_valid = tx_sk_valid;

   // ----------------------------------------
   // Event counters and request state
   // ----------------------------------------
   thr_t rx_thr, tx_thr;
   logic rx_pin_mv, rx_dma_mv, tx_pin_mv, tx_dma_mv;
   logic [7:0] rx_pc_q, rx_pc_d, rx_dc_q, rx_dc_d, tx_pc_q, tx_pc_d, tx_dc_q, tx_dc_d;
   logic rx_req_q, rx_req_d, tx_req_q, tx_req_d;
   logic rx_set, rx_clr, tx_set, tx_clr;
   logic rx_ovf_q, rx_ovf_d, tx_udf_q, tx_udf_d;
   logic rx_re_q, rx_rs_q, tx_re_q, tx_rs_q;
   logic rx_re_d, rx_rs_d, tx_re_d, tx_rs_d;

   function automatic logic [7:0] step(input logic [7:0] c, input logic mv, input thr_t t,
                                       output logic hit);
      hit = mv && (c + 8'h01 >= t);
      step = !mv ? c : (hit ? 8'h00 : c + 8'h01);
   endfunction : step

   assign rx_thr = rx_fifo_control[`THR_MSB:`THR_LSB];
   assign tx_thr = tx_fifo_control[`THR_MSB:`THR_LSB];
   assign rx_pin_mv = rx_pin_valid && rx_sk_ready;
   assign rx_dma_mv = rx_st_valid && rx_dma_ready;
   assign tx_dma_mv = tx_dma_valid && tx_st_ready;
   assign tx_pin_mv = tx_sk_valid && tx_pin_ready;

   always_comb
   begin
      rx_pc_d = step(rx_pc_q, rx_pin_mv, rx_thr, rx_set);
      rx_dc_d = step(rx_dc_q, rx_dma_mv, rx_thr, rx_clr);
      tx_pc_d = step(tx_pc_q, tx_pin_mv, tx_thr, tx_set);
      tx_dc_d = step(tx_dc_q, tx_dma_mv, tx_thr, tx_clr);
      // Set wins over clear in the same cycle
      rx_req_d = rx_set ? 1'b1 : (rx_clr ? 1'b0 : rx_req_q);
      tx_req_d = tx_set ? 1'b1 : (tx_clr ? 1'b0 : tx_req_q);
      // Sticky until software clears; a new error wins
      rx_ovf_d = (rx_pin_valid && !rx_sk_ready) || (rx_ovf_q && !err_clear);
      tx_udf_d = (tx_pin_ready && !tx_sk_valid) || (tx_udf_q && !err_clear);
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rx_pc_q <= 8'h00;
         rx_dc_q <= 8'h00;
         tx_pc_q <= 8'h00;
         tx_dc_q <= 8'h00;
         rx_req_q <= 1'b0;
         tx_req_q <= 1'b0;
         rx_ovf_q <= 1'b0;
         tx_udf_q <= 1'b0;
      end
      else if (ce)
      begin
         rx_pc_q <= rx_pc_d;
         rx_dc_q <= rx_dc_d;
         tx_pc_q <= tx_pc_d;
         tx_dc_q <= tx_dc_d;
         rx_req_q <= rx_req_d;
         tx_req_q <= tx_req_d;
         rx_ovf_q <= rx_ovf_d;
         tx_udf_q <= tx_udf_d;
      end
   end

   // ----------------------------------------
   // Request routing
   // ----------------------------------------
   // Route the next level so outputs never lag the request state
   always_comb
   begin
      rx_re_d = rx_req_d && (dma_select == dma_sel_enhanced);
      rx_rs_d = rx_req_d && (dma_select == dma_sel_system);
      tx_re_d = tx_req_d && (dma_select == dma_sel_enhanced);
      tx_rs_d = tx_req_d && (dma_select == dma_sel_system);
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rx_re_q <= 1'b0;
         rx_rs_q <= 1'b0;
         tx_re_q <= 1'b0;
         tx_rs_q <= 1'b0;
      end
      else if (ce)
      begin
         rx_re_q <= rx_re_d;
         rx_rs_q <= rx_rs_d;
         tx_re_q <= tx_re_d;
         tx_rs_q <= tx_rs_d;
      end
   end

   assign rx_req_enhanced_dma_controller = rx_re_q;
   assign rx_req_sdma = rx_rs_q;
   assign tx_req_enhanced_dma_controller = tx_re_q;
   assign tx_req_sdma = tx_rs_q;
   assign rx_overflow = rx_ovf_q;
   assign tx_underflow = tx_udf_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // Set and clear landing on one edge
   sequence coincide_s;
      ce && rx_set && rx_clr;
   endsequence

   rx_set_win_a: assert property (@(posedge clk) disable iff (!nrst)
      coincide_s |=> rx_req_q) else $error("rx request lost on coincidence");
   tx_set_win_a: assert property (@(posedge clk) disable iff (!nrst)
      ce && tx_set |=> tx_req_q) else $error("tx request lost on set");
   rx_req_hold_a: assert property (@(posedge clk) disable iff (!nrst)
      ce && rx_req_q && !rx_clr |=> rx_req_q) else $error("rx request dropped");
   tx_req_hold_a: assert property (@(posedge clk) disable iff (!nrst)
      ce && tx_req_q && !tx_clr |=> tx_req_q) else $error("tx request dropped");
   rx_clear_a: assert property (@(posedge clk) disable iff (!nrst)
      ce && rx_clr && !rx_set |=> !rx_req_q) else $error("rx request not cleared");
   tx_clear_a: assert property (@(posedge clk) disable iff (!nrst)
      ce && tx_clr && !tx_set |=> !tx_req_q) else $error("tx request not cleared");
   route_excl_a: assert property (@(posedge clk) disable iff (!nrst)
      !(rx_req_enhanced_dma_controller && rx_req_sdma)) else $error("rx request on both controllers");
   tx_route_excl_a: assert property (@(posedge clk) disable iff (!nrst)
      !(tx_req_enhanced_dma_controller && tx_req_sdma)) else $error("tx request on both controllers");
   route_follow_a: assert property (@(posedge clk) disable iff (!nrst)
      ce |=> ((rx_req_enhanced_dma_controller || rx_req_sdma) == rx_req_q)) else $error("rx routing mismatch");
   rx_ovf_sticky_a: assert property (@(posedge clk) disable iff (!nrst)
      ce && rx_pin_valid && !rx_sk_ready |=> rx_overflow) else $error("overflow missed");
   tx_udf_sticky_a: assert property (@(posedge clk) disable iff (!nrst)
      ce && tx_pin_ready && !tx_sk_valid |=> tx_underflow) else $error("underflow missed");
   fifo_cap_a: assert property (@(posedge clk) disable iff (!nrst)
      rx_lvl <= LW'(DEPTH) && tx_lvl <= LW'(DEPTH)) else $error("fifo level beyond depth");
endmodule : audio_fifo_dma_event

// *** rtl/audio_fifo_params.svh ***
`ifndef AUDIO_FIFO_PARAMS_SVH
`define AUDIO_FIFO_PARAMS_SVH
`define THR_MSB 15
`define THR_LSB 8
`define THR_RESET 8'h01
`define CTL_RESET 32'h0000_0100
`define SIDE_FIFO_DEPTH 16
`define MAIN_FIFO_DEPTH 64
`define WORD_WIDTH 32
`endif

// *** rtl/audio_fifo_pkg.sv ***
`include "audio_fifo_params.svh"
package audio_fifo_pkg;
   typedef logic [`WORD_WIDTH-1:0] word_t;
   typedef logic [7:0] thr_t;
   typedef enum logic {dma_sel_system, dma_sel_enhanced} dma_sel_t;
endpackage : audio_fifo_pkg

// *** rtl/stream_fifo.sv ***
`include "audio_fifo_params.svh"
module stream_fifo #(
   parameter int WIDTH = `WORD_WIDTH,
   parameter int DEPTH = `SIDE_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic clr,
   // Write side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Read side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // Status
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0] cnt_q, cnt_d;
   logic wr, rd;

   function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
      inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : inc

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rp_q];
   assign level = cnt_q;
   assign wr = in_valid && in_ready;
   assign rd = out_valid && out_ready;

   always_comb
   begin
      wp_d = wr ? inc(wp_q) : wp_q;
      rp_d = rd ? inc(rp_q) : rp_q;
      cnt_d = cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
      if (clr)
      begin
         wp_d = '0;
         rp_d = '0;
         cnt_d = '0;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end
      else if (ce)
      begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge clk)
   begin
      if (ce && wr && !clr)
      begin
         mem_q[wp_q] <= in_data;
      end
   end
endmodule : stream_fifo

// *** test/audio_fifo_dma_event_tb_top.sv ***
module audio_fifo_dma_event_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import audio_fifo_pkg::*;
   logic clk, nrst, ce, err_clear, rx_pin_valid, tx_pin_ready, dma_en, slow, prime;
   logic rx_pin_ready, rx_dma_valid, rx_dma_ready, tx_dma_valid, tx_dma_ready, tx_pin_valid;
   logic rx_req_enhanced_dma_controller, rx_req_sdma, tx_req_enhanced_dma_controller, tx_req_sdma, rx_overflow, tx_underflow;
   logic [31:0] rx_fifo_control, tx_fifo_control;
   dma_sel_t dma_select;
   word_t rx_pin_data, rx_dma_data, tx_dma_data, tx_pin_data;
   int error_cnt = 0, checks = 0, cyc = 0, rx_sent = 0, rx_got = 0, tx_got = 0;

   audio_fifo_dma_event audio_fifo_dma_event_i (.clk, .nrst, .ce, .rx_fifo_control,
      .tx_fifo_control, .dma_select, .err_clear, .rx_pin_valid, .rx_pin_ready, .rx_pin_data,
      .rx_dma_valid, .rx_dma_ready, .rx_dma_data, .tx_dma_valid, .tx_dma_ready, .tx_dma_data,
      .tx_pin_valid, .tx_pin_ready, .tx_pin_data, .rx_req_enhanced_dma_controller, .rx_req_sdma, .tx_req_enhanced_dma_controller,
      .tx_req_sdma, .rx_overflow, .tx_underflow);
   dma_model dma_model_i (.clk, .nrst, .en(dma_en), .slow, .prime,
      .rx_thr(rx_fifo_control[15:8]), .tx_thr(tx_fifo_control[15:8]),
      .rx_req(rx_req_enhanced_dma_controller | rx_req_sdma), .tx_req(tx_req_enhanced_dma_controller | tx_req_sdma),
      .rx_dma_valid, .rx_dma_ready, .tx_dma_ready, .tx_dma_valid, .tx_dma_data);

   task automatic tally_and_finish();
      if (error_cnt == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // ---------------------------------------------
   // Clock, watchdog and data monitors
   // ---------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         $display("CHECK FAILED run length expected %0d seen %0d", 19999, cyc);
         tally_and_finish();
      end
   end
   always @(posedge clk)
   begin
      if (nrst && rx_dma_valid && rx_dma_ready)
      begin
         chk("rx_dma_data", 32'h0000_a000 + 32'(rx_got), rx_dma_data);
         rx_got++;
      end
      if (nrst && tx_pin_valid && tx_pin_ready)
      begin
         chk("tx_pin_data", 32'h0000_1000 + 32'(tx_got), tx_pin_data);
         tx_got++;
      end
   end

   // ---------------------------------------------
   // Pin side drivers
   // ---------------------------------------------
   task automatic do_reset();
      @(negedge clk);
      nrst = 1'b0;
      dma_en = 1'b0;
      slow = 1'b0;
      repeat (5) @(negedge clk);
      nrst = 1'b1;
      rx_sent = 0;
      rx_got = 0;
      tx_got = 0;
   endtask : do_reset

   task automatic push(input int n);
      for (int i = 0; i < n; i++)
      begin
         @(negedge clk);
         rx_pin_valid = 1'b1;
         rx_pin_data = 32'h0000_a000 + 32'(rx_sent);
         do @(posedge clk); while (rx_pin_ready !== 1'b1);
         rx_sent++;
      end
      @(negedge clk);
      rx_pin_valid = 1'b0;
   endtask : push

   task automatic take(input int n);
      for (int i = 0; i < n; i++)
      begin
         @(negedge clk);
         while (tx_pin_valid !== 1'b1)
         begin
            tx_pin_ready = 1'b0;
            @(negedge clk);
         end
         tx_pin_ready = 1'b1;
         @(posedge clk);
      end
      @(negedge clk);
      tx_pin_ready = 1'b0;
   endtask : take

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic sc_rx_event(input dma_sel_t s, input logic sl);
      do_reset();
      dma_select = s;
      slow = sl;
      rx_fifo_control = 32'h8000_0401;
      push(3);
      repeat (3) @(negedge clk);
      chk("rx early", 0, {rx_req_enhanced_dma_controller, rx_req_sdma});
      push(1);
      @(negedge clk);
      chk("rx req", {s == dma_sel_enhanced, s == dma_sel_system}, {rx_req_enhanced_dma_controller, rx_req_sdma});
      chk("tx req", 0, {tx_req_enhanced_dma_controller, tx_req_sdma});
      repeat (12) @(negedge clk);
      chk("rx held", 1, rx_req_enhanced_dma_controller | rx_req_sdma);
      dma_en = 1'b1;
      repeat (20) @(negedge clk);
      chk("rx cleared", 0, {rx_req_enhanced_dma_controller, rx_req_sdma});
      chk("rx words", 4, rx_got);
   endtask : sc_rx_event

   task automatic sc_coincide(input int off);
      do_reset();
      rx_fifo_control = 32'h0000_0200;
      push(3);
      repeat (8) @(negedge clk);
      dma_en = 1'b1;
      repeat (off + 1) @(negedge clk);
      push(1);
      repeat (20) @(negedge clk);
      chk("rx all read", rx_sent, rx_got);
      chk("rx idle", 0, {rx_req_enhanced_dma_controller, rx_req_sdma});
   endtask : sc_coincide

   task automatic sc_overflow();
      do_reset();
      rx_fifo_control = 32'h0000_2000;
      @(negedge clk);
      rx_pin_valid = 1'b1;
      for (int i = 0; i < 200; i++)
      begin
         rx_pin_data = 32'h0000_a000 + 32'(rx_sent);
         @(posedge clk);
         if (rx_pin_ready !== 1'b1)
            break;
         rx_sent++;
         @(negedge clk);
      end
      @(negedge clk);
      rx_pin_valid = 1'b0;
      @(negedge clk);
      chk("rx capacity", 64 + 16, rx_sent);
      chk("rx_overflow", 1, rx_overflow);
      chk("tx_underflow", 0, tx_underflow);
      ce = 1'b0;
      err_clear = 1'b1;
      @(negedge clk);
      chk("rx_overflow frozen", 1, rx_overflow);
      ce = 1'b1;
      @(negedge clk);
      err_clear = 1'b0;
      @(negedge clk);
      chk("rx_overflow cleared", 0, rx_overflow);
      slow = 1'b1;
      dma_en = 1'b1;
      repeat (120) @(negedge clk);
      chk("rx one batch", 32, rx_got);
   endtask : sc_overflow

   task automatic sc_tx(input dma_sel_t s);
      do_reset();
      dma_select = s;
      tx_fifo_control = 32'h0000_0400;
      dma_en = 1'b1;
      prime = 1'b1;
      @(negedge clk);
      prime = 1'b0;
      repeat (12) @(negedge clk);
      chk("tx early", 0, {tx_req_enhanced_dma_controller, tx_req_sdma});
      take(4);
      @(negedge clk);
      chk("tx req", {s == dma_sel_enhanced, s == dma_sel_system}, {tx_req_enhanced_dma_controller, tx_req_sdma});
      repeat (12) @(negedge clk);
      chk("tx cleared", 0, {tx_req_enhanced_dma_controller, tx_req_sdma});
      take(4);
      dma_en = 1'b0;
      tx_pin_ready = 1'b1;
      @(negedge clk);
      tx_pin_ready = 1'b0;
      @(negedge clk);
      chk("tx_underflow", 1, tx_underflow);
      chk("rx_overflow", 0, rx_overflow);
      chk("tx words", 8, tx_got);
      chk("tx held", 1, tx_req_enhanced_dma_controller | tx_req_sdma);
   endtask : sc_tx

   initial
   begin
      {nrst, err_clear, rx_pin_valid, tx_pin_ready, dma_en, slow, prime} = 7'h00;
      ce = 1'b1;
      rx_fifo_control = 32'h0000_0100;
      tx_fifo_control = 32'h0000_0100;
      dma_select = dma_sel_system;
      rx_pin_data = 32'h0000_0000;
      do_reset();
      chk("reset state", 8'hc0, {rx_pin_ready, tx_dma_ready, rx_req_enhanced_dma_controller, rx_req_sdma,
         tx_req_enhanced_dma_controller, tx_req_sdma, rx_overflow, tx_underflow});
      sc_rx_event(dma_sel_system, 1'b0);
      sc_rx_event(dma_sel_enhanced, 1'b1);
      for (int off = 0; off < 2; off++)
         sc_coincide(off);
      sc_overflow();
      sc_tx(dma_sel_system);
      sc_tx(dma_sel_enhanced);
      tally_and_finish();
   end
endmodule : audio_fifo_dma_event_tb_top

// *** test/dma_model.sv ***
module dma_model (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Control
   input wire logic en,
   input wire logic slow,
   input wire logic prime,
   input wire audio_fifo_pkg::thr_t rx_thr,
   input wire audio_fifo_pkg::thr_t tx_thr,
   // Requests and streams
   input wire logic rx_req,
   input wire logic tx_req,
   input wire logic rx_dma_valid,
   output logic rx_dma_ready,
   input wire logic tx_dma_ready,
   output logic tx_dma_valid,
   output audio_fifo_pkg::word_t tx_dma_data
);
   timeunit 1ns;
   timeprecision 1ps;
   import audio_fifo_pkg::*;
   int rx_left;
   int tx_left;
   int tx_seq;
   logic rx_hold;
   logic tx_hold;
   logic tick;
   word_t tx_word;
   assign tx_word = 32'h0000_1000 + word_t'(tx_seq);
   // Released bus shows inverted data
   assign tx_dma_data = tx_dma_valid ? tx_word : ~tx_word;
   assign rx_dma_ready = (rx_left > 0) && (!slow || tick);
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rx_left <= 0;
         tx_left <= 0;
         tx_seq <= 0;
         rx_hold <= 1'b0;
         tx_hold <= 1'b0;
         tick <= 1'b0;
         tx_dma_valid <= 1'b0;
      end
      else
      begin
         tick <= !tick;
         rx_hold <= 1'b0;
         tx_hold <= 1'b0;
         // One batch per request, skip the cycle the request drops in
         if (rx_left == 0 && !rx_hold && en && rx_req)
            rx_left <= (rx_thr == 8'h00) ? 1 : int'(rx_thr);
         else if (rx_dma_valid && rx_dma_ready)
         begin
            rx_left <= rx_left - 1;
            rx_hold <= (rx_left == 1);
         end
         if (tx_dma_valid && tx_dma_ready)
         begin
            tx_seq <= tx_seq + 1;
            tx_left <= tx_left - 1;
            tx_dma_valid <= (tx_left > 1) && !slow;
            tx_hold <= (tx_left == 1);
         end
         else if (tx_left > 0)
            tx_dma_valid <= 1'b1;
         else if (!tx_hold && en && (tx_req || prime))
            tx_left <= (tx_thr == 8'h00) ? 1 : int'(tx_thr);
      end
   end
endmodule : dma_model
